// ==== core/dmd_params.svh ====
// Constants for the dual bank memory decoder
`ifndef DMD_PARAMS_SVH
`define DMD_PARAMS_SVH
`define DMD_ADDR_W        16
`define DMD_BANK_BIT      15
`define DMD_INT_DATA_TOP  16'h0400
`define DMD_SERIAL_TOP    16'h0002
`define DMD_B0_DATA_LO    16'h0200
`define DMD_B0_DATA_HI    16'h02ff
`define DMD_B0_PROG_LO    16'hff00
`define DMD_MON_LO        16'h0400
`define DMD_MON_HI        16'h1000
`define DMD_RUN_ADDR      16'h1008
`define DMD_FLAG_RST      1'b1
`define DMD_B0_PROG_RST   1'b0
`define DMD_SLOW_DIV_A    2
`define DMD_SLOW_DIV_B    4
`define DMD_FAST_DIV      1
`define DMD_CNT_W         3
`endif

// ==== core/dmd_pkg.sv ====
// Types shared by both ends of the memory decoder
package dmd_pkg;
   typedef logic [15:0] dmd_addr_t;

   typedef enum logic [0:0] {
      DMD_H_IDLE = 1'b0,
      DMD_H_JUMP = 1'b1
   } dmd_hstate_t;
endpackage

// ==== core/dmd_if.sv ====
// Link between processor core and memory decoder
`timescale 1ns/1ps
interface dmd_if;
   import dmd_pkg::*;
   logic      bank_select_flag;
   logic      prog_strobe;
   logic      data_strobe;
   logic      wr;
   dmd_addr_t addr;
   logic      b0_is_prog;
   logic      cpu_clk_en;

   modport dev (
      input  bank_select_flag,
      input  prog_strobe,
      input  data_strobe,
      input  wr,
      input  addr,
      input  b0_is_prog,
      output cpu_clk_en
   );
   modport host (
      output bank_select_flag,
      output prog_strobe,
      output data_strobe,
      output wr,
      output addr,
      output b0_is_prog,
      input  cpu_clk_en
   );
endinterface

// ==== core/dmd_clk_div.sv ====
// Processor clock enable divider with glitch-free ratio change
`timescale 1ns/1ps
`include "dmd_params.svh"
module dmd_clk_div #(
   parameter int DIV_A = `DMD_SLOW_DIV_A,
   parameter int DIV_B = `DMD_SLOW_DIV_B
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_slow,
   input  wire logic i_div_b,
   output logic      o_en
);
   import dmd_pkg::*;

   // Counter reloads with divisor minus one, so its width caps the divisor
   if (DIV_A < 1 || DIV_B < 1 ||
       DIV_A > (1 << `DMD_CNT_W) ||
       DIV_B > (1 << `DMD_CNT_W)) begin : g_bad_div
      $error("dmd_clk_div: divisors must fit the counter");
   end

   typedef struct packed {
      logic [`DMD_CNT_W-1:0] cnt;
   } dmd_div_st_t;

   dmd_div_st_t st_r;
   dmd_div_st_t st_nxt;

   localparam logic [`DMD_CNT_W-1:0] LD_A = `DMD_CNT_W'(DIV_A - 1);
   localparam logic [`DMD_CNT_W-1:0] LD_B = `DMD_CNT_W'(DIV_B - 1);
   localparam logic [`DMD_CNT_W-1:0] LD_F = `DMD_CNT_W'(`DMD_FAST_DIV - 1);

   assign o_en = (st_r.cnt == '0);

   always_comb begin
      st_nxt = st_r;
      // Ratio sampled only on an enable cycle, so no runt period
      if (o_en) begin
         if (i_slow) begin
            st_nxt.cnt = i_div_b ? LD_B : LD_A;
         end else begin
            st_nxt.cnt = LD_F;
         end
      end else begin
         st_nxt.cnt = st_r.cnt - `DMD_CNT_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

// ==== core/dmd_decoder.sv ====
// Memory decode and bank switch logic, board end
// What this block does
// - Processor raises bank flag after reset
// - Flag high: boot EPROM is program low half
// - Flag high: processor clock divided by two/four
// - Flag high: first SRAM bank is data
// - Flag low: bank one program, two data
// - Flag low: boot EPROM never selected
// - No external data below 0400h
// - No external program FF00h up when block is program
// - One address selects one 16-bit word
// - Processor resets internal block into data space
// - Internal block at 0200h data or FF00h program
// - Run: clear flag, then jump to 1008h
// - Fit input adds slow data and fast program above 8000h, and fast data below 8000h
// - Fast monitor lives at program 0400h-1000h
// - Monitor reset overwrites block words to 0275h
// - Data words 0 and 1 are serial registers
`timescale 1ns/1ps
`include "dmd_params.svh"
module dmd_decoder #(
   parameter int SLOW_DIV_A = `DMD_SLOW_DIV_A,
   parameter int SLOW_DIV_B = `DMD_SLOW_DIV_B
) (
   input  wire logic I_CLK,
   input  wire logic I_RST_N,
   dmd_if.dev        link,
   input  wire logic I_SPEED_DIVIDER_JUMPER,
   input  wire logic I_UPPER_FITTED,
   output logic      O_CE_EPROM,
   output logic      O_CE_SRAM0_LO,
   output logic      O_CE_SRAM0_HI,
   output logic      O_CE_SRAM1_LO,
   output logic      O_CE_SRAM1_HI,
   output logic [14:0] O_WORD_ADDR,
   output logic      O_SLOW_MODE
);
   import dmd_pkg::*;

   if (SLOW_DIV_A < 1 || SLOW_DIV_B < 1 ||
       SLOW_DIV_A > (1 << `DMD_CNT_W) ||
       SLOW_DIV_B > (1 << `DMD_CNT_W)) begin : g_bad_div
      $error("dmd_decoder: slow divisors must fit the divider");
   end

   // ********************************************
   // State: pin synchronisers
   // ********************************************
   typedef struct packed {
      logic [1:0] jmp_sync;
      logic [1:0] fit_sync;
   } dmd_dec_st_t;

   dmd_dec_st_t st_r;
   dmd_dec_st_t st_nxt;

   logic jumper_s;
   logic fitted_s;

   assign jumper_s = st_r.jmp_sync[1];
   assign fitted_s = st_r.fit_sync[1];

   always_comb begin
      st_nxt          = st_r;
      st_nxt.jmp_sync = {st_r.jmp_sync[0], I_SPEED_DIVIDER_JUMPER};
      st_nxt.fit_sync = {st_r.fit_sync[0], I_UPPER_FITTED};
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ********************************************
   // Processor clock enable
   // ********************************************
   dmd_clk_div #(
      .DIV_A (SLOW_DIV_A),
      .DIV_B (SLOW_DIV_B)
   ) u_div (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_slow  (link.bank_select_flag),
      .i_div_b (jumper_s),
      .o_en    (link.cpu_clk_en)
   );

   // ********************************************
   // Address decode
   // ********************************************
   logic slow;
   logic hi;
   logic prog_ext;
   logic data_ext;
   logic use_prog;
   logic use_data;

   // Flag from processor logic on this clock, no synchroniser
   assign slow = link.bank_select_flag;
   assign O_SLOW_MODE = slow;
   // Word addressing: bit 15 picks the pair, rest goes to chips
   assign hi = link.addr[`DMD_BANK_BIT];
   assign O_WORD_ADDR = link.addr[`DMD_BANK_BIT-1:0];

   always_comb begin
      data_ext = link.data_strobe;
      if (link.addr < `DMD_INT_DATA_TOP) begin
         data_ext = 1'b0;
      end
      prog_ext = link.prog_strobe;
      if (link.b0_is_prog && link.addr >= `DMD_B0_PROG_LO) begin
         prog_ext = 1'b0;
      end
      // One address bus: program wins if both strobes collide
      use_prog = prog_ext;
      use_data = data_ext && !prog_ext;
   end

   always_comb begin
      O_CE_EPROM    = 1'b0;
      O_CE_SRAM0_LO = 1'b0;
      O_CE_SRAM0_HI = 1'b0;
      O_CE_SRAM1_LO = 1'b0;
      O_CE_SRAM1_HI = 1'b0;
      if (slow) begin
         // EPROM covers low half only; upper program reads float
         O_CE_EPROM    = use_prog && !hi;
         O_CE_SRAM0_LO = use_data && !hi;
         O_CE_SRAM0_HI = use_data && hi && fitted_s;
      end else begin
         // Boot EPROM stays dark in fast mode
         O_CE_SRAM0_LO = use_prog && !hi;
         O_CE_SRAM0_HI = use_prog && hi && fitted_s;
         O_CE_SRAM1_LO = use_data && !hi && fitted_s;
         O_CE_SRAM1_HI = use_data && hi;
      end
   end
endmodule

// ==== core/dmd_host.sv ====
// Processor core end: flag, block config and strobes
`timescale 1ns/1ps
`include "dmd_params.svh"
module dmd_host (
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   dmd_if.host              link,
   input  wire logic        I_SET_FLAG_INSTRUCTION,
   input  wire logic        I_CLEAR_FLAG_INSTRUCTION,
   input  wire logic        I_CONFIGURE_PROGRAM_INSTRUCTION,
   input  wire logic        I_CONFIGURE_DATA_INSTRUCTION,
   input  wire logic        I_MONITOR_RESET,
   input  wire logic        I_RUN,
   input  wire logic        I_REQ,
   input  wire logic        I_PROG_SPACE,
   input  wire logic        I_WR,
   input  dmd_pkg::dmd_addr_t I_ADDR,
   output logic             O_INTERNAL,
   output logic             O_SERIAL_HIT,
   output logic             O_REFUSED,
   output logic             O_BUSY
);
   import dmd_pkg::*;

   // ********************************************
   // State
   // ********************************************
   typedef struct packed {
      dmd_hstate_t state;
      logic        flag;
      logic        b0_prog;
      logic        ps;
      logic        ds;
      logic        wr;
      dmd_addr_t   addr;
      logic        internal;
      logic        serial;
      logic        refused;
   } dmd_host_st_t;

   dmd_host_st_t st_r;
   dmd_host_st_t st_nxt;

   assign link.bank_select_flag = st_r.flag;
   assign link.b0_is_prog       = st_r.b0_prog;
   assign link.prog_strobe      = st_r.ps;
   assign link.data_strobe      = st_r.ds;
   assign link.wr               = st_r.wr;
   assign link.addr             = st_r.addr;
   assign O_INTERNAL            = st_r.internal;
   assign O_SERIAL_HIT          = st_r.serial;
   assign O_REFUSED             = st_r.refused;
   assign O_BUSY                = (st_r.state != DMD_H_IDLE);

   // ********************************************
   // Next state, advanced on processor cycles only
   // ********************************************
   always_comb begin
      st_nxt = st_r;
      if (link.cpu_clk_en) begin
         st_nxt.ps       = 1'b0;
         st_nxt.ds       = 1'b0;
         st_nxt.wr       = 1'b0;
         st_nxt.internal = 1'b0;
         st_nxt.serial   = 1'b0;
         st_nxt.refused  = 1'b0;
         if (I_SET_FLAG_INSTRUCTION) begin
            st_nxt.flag = 1'b1;
         end else if (I_CLEAR_FLAG_INSTRUCTION) begin
            st_nxt.flag = 1'b0;
         end
         if (I_CONFIGURE_PROGRAM_INSTRUCTION) begin
            st_nxt.b0_prog = 1'b1;
         end else if (I_CONFIGURE_DATA_INSTRUCTION) begin
            st_nxt.b0_prog = 1'b0;
         end
         // Monitor reset back to slow mode; block words to 0275h lost
         if (I_MONITOR_RESET) begin
            st_nxt.flag    = 1'b1;
            st_nxt.b0_prog = 1'b0;
            st_nxt.state   = DMD_H_IDLE;
         end else begin
            case (st_r.state)
               DMD_H_IDLE: begin
                  if (I_RUN) begin
                     st_nxt.flag  = 1'b0;
                     st_nxt.state = DMD_H_JUMP;
                  end else if (I_REQ) begin
                     st_nxt.addr = I_ADDR;
                     st_nxt.wr   = I_WR;
                     if (I_PROG_SPACE) begin
                        st_nxt.ps = 1'b1;
                        st_nxt.internal = st_r.b0_prog &&
                           I_ADDR >= `DMD_B0_PROG_LO;
                        // Guard the fast monitor from stray writes
                        if (I_WR && !st_r.flag &&
                            I_ADDR >= `DMD_MON_LO &&
                            I_ADDR <= `DMD_MON_HI) begin
                           st_nxt.ps      = 1'b0;
                           st_nxt.wr      = 1'b0;
                           st_nxt.refused = 1'b1;
                        end
                     end else begin
                        st_nxt.ds = 1'b1;
                        st_nxt.internal =
                           I_ADDR < `DMD_INT_DATA_TOP;
                        st_nxt.serial =
                           I_ADDR < `DMD_SERIAL_TOP;
                     end
                  end
               end
               DMD_H_JUMP: begin
                  // Flag already low: fetch lands in fast SRAM
                  st_nxt.ps    = 1'b1;
                  st_nxt.addr  = `DMD_RUN_ADDR;
                  st_nxt.state = DMD_H_IDLE;
               end
               default: begin
                  st_nxt.state = DMD_H_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_r         <= '0;
         st_r.state   <= DMD_H_IDLE;
         st_r.flag    <= `DMD_FLAG_RST;
         st_r.b0_prog <= `DMD_B0_PROG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

// ==== tb/dmd_assertions.sv ====
// Link checks for the memory decoder: chip enables and clock divider
`timescale 1ns/1ps
module dmd_assertions (
   input wire logic               I_CLK,
   input wire logic               I_RST_N,
   input wire logic               bank_select_flag,
   input wire logic               prog_strobe,
   input wire logic               data_strobe,
   input wire logic               b0_is_prog,
   input wire logic               cpu_clk_en,
   input wire dmd_pkg::dmd_addr_t addr,
   input wire logic [14:0]        O_WORD_ADDR,
   input wire logic               O_CE_EPROM,
   input wire logic               O_CE_SRAM0_LO,
   input wire logic               O_CE_SRAM0_HI,
   input wire logic               O_CE_SRAM1_LO,
   input wire logic               O_CE_SRAM1_HI
);
   // ****************************************
   // Properties
   // ****************************************
   wire logic [4:0] ce = {O_CE_EPROM, O_CE_SRAM0_LO, O_CE_SRAM0_HI,
                          O_CE_SRAM1_LO, O_CE_SRAM1_HI};
   wire logic fl = bank_select_flag;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   a_eprom_slow_only: assert property (
      O_CE_EPROM |-> fl && prog_strobe && !addr[15])
      else $error("eprom enabled outside slow low program");
   a_slow_prog_eprom: assert property (
      fl && prog_strobe && !addr[15] |-> O_CE_EPROM)
      else $error("slow low program missed eprom");
   a_sram1_fast_only: assert property (
      O_CE_SRAM1_LO || O_CE_SRAM1_HI |-> !fl)
      else $error("second bank enabled in slow mode");
   a_fast_prog_bank: assert property (
      !fl && prog_strobe && !addr[15] |-> O_CE_SRAM0_LO)
      else $error("fast low program missed first bank");
   a_low_data_none: assert property (
      data_strobe && !prog_strobe && addr < 16'h0400 |-> ce == 5'h00)
      else $error("external enable on internal data");
   a_b0_prog_hole: assert property (
      prog_strobe && b0_is_prog && addr >= 16'hff00 |-> ce == 5'h00)
      else $error("external enable under internal program block");
   a_one_pair: assert property ($onehot0(ce))
      else $error("more than one pair enabled");
   a_word_addr: assert property (O_WORD_ADDR == addr[14:0])
      else $error("word address not passed through");
   a_slow_div_gap: assert property (
      cpu_clk_en && fl |=> !cpu_clk_en)
      else $error("slow mode clock not divided");
   a_fast_clk_run: assert property (!fl [*6] |-> cpu_clk_en)
      else $error("fast mode clock not running every cycle");
endmodule

// ==== tb/dual_bank_memory_decoder_tb.sv ====
// Self-checking bench joining both ends of the memory decoder
`timescale 1ns/1ps
module dual_bank_memory_decoder_tb;
   import dmd_pkg::*;
   typedef struct packed {
      logic s; logic [1:0] pw; dmd_addr_t a; logic [4:0] ce;
   } dmd_row_t;
   localparam logic [8:0] SET = 9'h100, CLR = 9'h080, CFGP = 9'h040;
   localparam logic [8:0] MRST = 9'h010, RUN = 9'h008, REQ = 9'h004;
   localparam logic [8:0] PS = 9'h002, WR = 9'h001;
   // Mode, {space, write}, address, enables {eprom,s0lo,s0hi,s1lo,s1hi}
   localparam dmd_row_t rows [12] = '{
      '{1'h0, 2'h2, 16'h0000, 5'h08}, '{1'h0, 2'h2, 16'h8000, 5'h04},
      '{1'h0, 2'h2, 16'hff00, 5'h04}, '{1'h0, 2'h1, 16'h0400, 5'h02},
      '{1'h0, 2'h0, 16'hffff, 5'h01}, '{1'h0, 2'h0, 16'h03ff, 5'h00},
      '{1'h1, 2'h2, 16'h0000, 5'h10}, '{1'h1, 2'h2, 16'h7fff, 5'h10},
      '{1'h1, 2'h2, 16'h8000, 5'h00}, '{1'h1, 2'h0, 16'h0400, 5'h08},
      '{1'h1, 2'h0, 16'h8000, 5'h04}, '{1'h1, 2'h1, 16'h03ff, 5'h00}};
   logic        clk, rst_n, jmp, fit, intl, ser, refu, busy, slow;
   logic [8:0]  cmd;
   dmd_addr_t   adr;
   logic [4:0]  ce;
   logic [14:0] wa;
   int          bad_count = 0, num_checks = 0, n;
   dmd_if link ();
   dmd_host dmd_host_inst (.I_CLK(clk), .I_RST_N(rst_n), .link(link.host),
      .I_SET_FLAG_INSTRUCTION(cmd[8]), .I_CLEAR_FLAG_INSTRUCTION(cmd[7]),
      .I_CONFIGURE_PROGRAM_INSTRUCTION(cmd[6]),
      .I_CONFIGURE_DATA_INSTRUCTION(cmd[5]), .I_MONITOR_RESET(cmd[4]),
      .I_RUN(cmd[3]), .I_REQ(cmd[2]), .I_PROG_SPACE(cmd[1]), .I_WR(cmd[0]),
      .I_ADDR(adr), .O_INTERNAL(intl), .O_SERIAL_HIT(ser),
      .O_REFUSED(refu), .O_BUSY(busy));
   dmd_decoder dmd_decoder_inst (.I_CLK(clk), .I_RST_N(rst_n),
      .link(link.dev), .I_SPEED_DIVIDER_JUMPER(jmp), .I_UPPER_FITTED(fit),
      .O_CE_EPROM(ce[4]), .O_CE_SRAM0_LO(ce[3]), .O_CE_SRAM0_HI(ce[2]),
      .O_CE_SRAM1_LO(ce[1]), .O_CE_SRAM1_HI(ce[0]), .O_WORD_ADDR(wa),
      .O_SLOW_MODE(slow));
   dmd_assertions dmd_assertions_inst (.I_CLK(clk), .I_RST_N(rst_n),
      .bank_select_flag(link.bank_select_flag), .addr(link.addr),
      .prog_strobe(link.prog_strobe), .data_strobe(link.data_strobe),
      .b0_is_prog(link.b0_is_prog), .cpu_clk_en(link.cpu_clk_en),
      .O_WORD_ADDR(wa), .O_CE_EPROM(ce[4]), .O_CE_SRAM0_LO(ce[3]),
      .O_CE_SRAM0_HI(ce[2]), .O_CE_SRAM1_LO(ce[1]), .O_CE_SRAM1_HI(ce[0]));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Held until an enabled edge takes it; strobes show on that same edge
   task automatic op(input logic [8:0] c, input dmd_addr_t a);
      @(negedge clk);
      cmd = c;
      adr = a;
      for (n = 0; n < 8 && link.cpu_clk_en !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      cmd = 9'h000;
   endtask
   task automatic cnt(input logic [23:0] exp);
      int e;
      e = 0;
      repeat (8) @(negedge clk);
      repeat (16) begin
         @(negedge clk);
         e += int'(link.cpu_clk_en);
      end
      chk(e[23:0], exp);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #(40 * 5000);
      bad_count++;
      end_sim;
   end
   initial begin
      rst_n = 1'b0;
      {cmd, adr, jmp, fit} = {9'h000, 16'h0000, 1'b0, 1'b1};
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[k]) begin
         op(rows[k].s ? SET : CLR, 16'h0000);
         op(REQ | {7'h00, rows[k].pw}, rows[k].a);
         chk(ce, rows[k].ce);
         chk({wa, slow, link.wr},
             {rows[k].a[14:0], rows[k].s, rows[k].pw[0]});
         $display("row %0d done", k);
      end
      cnt(24'h8);
      jmp = 1'b1;
      cnt(24'h4);
      op(CLR, 16'h0000);
      cnt(24'h10);
      $display("divider test done");
      op(CFGP, 16'h0000);
      op(REQ | PS, 16'hff00);
      chk({link.b0_is_prog, ce}, 6'h20);
      op(REQ | PS, 16'hfeff);
      chk(ce, 5'h04);
      op(REQ | PS | WR, 16'h1000);
      chk({refu, link.prog_strobe}, 2'h2);
      op(REQ, 16'h0001);
      chk({intl, ser}, 2'h3);
      fit = 1'b0;
      repeat (3) @(negedge clk);
      op(REQ, 16'h0400);
      chk(ce, 5'h00);
      fit = 1'b1;
      op(MRST, 16'h0000);
      chk({link.bank_select_flag, link.b0_is_prog}, 2'h2);
      $display("fast mode tests done");
      op(RUN, 16'h0000);
      chk({link.bank_select_flag, busy}, 2'h1);
      for (n = 0; n < 8 && link.prog_strobe !== 1'b1; n++) @(negedge clk);
      chk({busy, link.addr, ce}, {1'h0, 16'h1008, 5'h08});
      $display("run test done");
      rst_n = 1'b0;
      @(negedge clk);
      chk({link.bank_select_flag, link.b0_is_prog, link.cpu_clk_en,
           link.prog_strobe}, 4'ha);
      rst_n = 1'b1;
      // First edge after release loads the slow period, so a gap follows
      @(negedge clk);
      chk({link.bank_select_flag, busy, link.cpu_clk_en}, 3'h4);
      $display("reset test done");
      end_sim;
   end
endmodule
